// file: buck_seq_pkg.sv
package buck_seq_pkg;

  // clock and switching rate
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SW_HZ = 600_000;
  // switching period rounds down, half period gives the 180 degree offset
  localparam int unsigned SW_PERIOD_CYC = CLK_HZ / SW_HZ;
  localparam int unsigned SW_HALF_CYC = SW_PERIOD_CYC / 2;
  localparam int unsigned SW_CNT_W = 7;

  // times in microseconds, as printed
  localparam int unsigned SS_TIME_US = 1000;
  localparam int unsigned HIC_WAIT_US = 500;
  localparam int unsigned HIC_TIME_US = 14000;
  localparam int unsigned POK_DEGLITCH_US = 100;
  localparam int unsigned STOP_GAP_US = 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // derived cycle counts
  localparam int unsigned SS_CYC = SS_TIME_US * CYC_PER_US;
  localparam int unsigned HIC_WAIT_CYC = HIC_WAIT_US * CYC_PER_US;
  localparam int unsigned HIC_TIME_CYC = HIC_TIME_US * CYC_PER_US;
  localparam int unsigned POK_DEGLITCH_CYC = POK_DEGLITCH_US * CYC_PER_US;
  localparam int unsigned STOP_GAP_CYC = STOP_GAP_US * CYC_PER_US;
  localparam int unsigned CNT_W = 20;

  // converter count and synchroniser width
  localparam int unsigned NCONV = 3;
  localparam int unsigned PIN_W = 39;

  // register map, byte addresses
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int unsigned CTRL_PSM_BIT = 0;
  localparam logic CTRL_PSM_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // comparator flags of one power stage
  typedef struct packed {
    logic in_window;   // feedback inside 95/105 window
    logic out_window;  // feedback outside 92.5/107.5 window
    logic overshoot;   // feedback above overvoltage threshold
    logic boot_low;    // boot capacitor below its lockout
    logic peak_trip;   // switch current reached reference
    logic zero_cur;    // inductor current reached zero
    logic err_low;     // loop error below low level
    logic src_limit;   // low-side sourcing limit
    logic sink_limit;  // low-side sinking limit
    logic overload;    // loop demands overload current
  } conv_flags_t;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_UP = 4'h2,
    SEQ_ON = 4'h4,
    SEQ_DOWN = 4'h8
  } seq_state_t;

  // status register layout
  typedef struct packed {
    logic [13:0] zero;
    logic pin_level;
    seq_state_t seq;
    logic auto_mode;
    logic lockout;
    logic thermal;
    logic pok;
    logic [2:0] win_ok;
    logic [2:0] hiccup;
    logic [2:0] active;
  } status_t;

  // state of one switch cell
  typedef struct packed {
    logic hs;
    logic ls;
    logic hold;
    logic hic;
    logic [CNT_W-1:0] cnt;
  } cell_state_t;

endpackage : buck_seq_pkg

// file: buck_switch_cell.sv
`timescale 1ns/1ps

module buck_switch_cell #(
  parameter int unsigned HIC_WAIT = buck_seq_pkg::HIC_WAIT_CYC,
  parameter int unsigned HIC_TIME = buck_seq_pkg::HIC_TIME_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic cycle_start,
  input wire logic psm_en,
  input wire buck_seq_pkg::conv_flags_t flags,
  // switch commands and state
  output logic hs_on,
  output logic ls_on,
  output logic in_hiccup
);

  buck_seq_pkg::cell_state_t s_r; // registered state
  buck_seq_pkg::cell_state_t s_nxt; // next state

  // switch decisions, later overrides win
  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      // converter stopped: both switches off
      s_nxt = '0;
    end else if (s_r.hic) begin
      // hiccup pause, then restart
      s_nxt.hs = 1'b0;
      s_nxt.ls = 1'b0;
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (s_r.cnt >= buck_seq_pkg::CNT_W'(HIC_TIME - 1)) begin
        s_nxt.hic = 1'b0;
        s_nxt.cnt = '0;
      end
    end else begin
      // cycle start: new high-side pulse unless skipped
      if (cycle_start) begin
        s_nxt.hold = 1'b0;
        if (flags.src_limit) begin
          s_nxt.hs = 1'b0;
          s_nxt.ls = 1'b1;
        end else begin
          s_nxt.hs = 1'b1;
          s_nxt.ls = 1'b0;
        end
      end
      // peak current ends the on-time
      if (flags.peak_trip && s_r.hs) begin
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b1;
      end
      // boot recharge
      if (flags.boot_low) begin
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b1;
      end
      // overshoot blocks high side until next cycle start
      if (flags.overshoot) begin
        s_nxt.hs = 1'b0;
      end
      // no reverse current in light load
      if (psm_en && flags.zero_cur) begin
        s_nxt.ls = 1'b0;
      end
      // sinking limit: both off for rest of cycle
      if (flags.sink_limit) begin
        s_nxt.hold = 1'b1;
      end
      if (s_nxt.hold) begin
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b0;
      end
      // low error level stops switching
      if (flags.err_low) begin
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b0;
      end
      // overload persistence timer
      s_nxt.cnt = flags.overload ? s_r.cnt + 1'b1 : '0;
      if (flags.overload && s_r.cnt >= buck_seq_pkg::CNT_W'(HIC_WAIT - 1)) begin
        s_nxt.hic = 1'b1;
        s_nxt.cnt = '0;
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hs_on = s_r.hs;
  assign ls_on = s_r.ls;
  assign in_hiccup = s_r.hic;

endmodule : buck_switch_cell

// file: buck_sequencer.sv
// How it works
// - select high with enable one or two set turns on automatic sequencing
// - enables one and two pick the order
// - enable three starts or stops the sequence
// - select low: each enable drives own converter
// - input lockout forces every converter off
// - boot low: high side off, low on
// - converter one switches half period offset
// - overshoot holds high side off till cycle
// - zero current turns low side off
// - low error level stops both switches of its own converter
// - peak current ends high-side on-time
// - sourcing limit skips next high-side pulse
// - sinking limit: both off rest of cycle
// - persistent overload causes hiccup shutdown, restart
// - power ok floats when all in window
// - power ok low when out of window
// - power ok low on faults, softstart, enables
// - overtemperature stops; cool-down reruns power-up
// - power ok after sequence, regulation, deglitch
// - converters two, three ramp one millisecond
`timescale 1ns/1ps

module buck_sequencer #(
  parameter int unsigned SS_CYC = buck_seq_pkg::SS_CYC,
  parameter int unsigned HIC_WAIT_CYC = buck_seq_pkg::HIC_WAIT_CYC,
  parameter int unsigned HIC_TIME_CYC = buck_seq_pkg::HIC_TIME_CYC,
  parameter int unsigned POK_DEGLITCH_CYC = buck_seq_pkg::POK_DEGLITCH_CYC,
  parameter int unsigned STOP_GAP_CYC = buck_seq_pkg::STOP_GAP_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // mode and enable pins
  input wire logic sequence_select,
  input wire logic converter_one_enable,
  input wire logic converter_two_enable,
  input wire logic converter_three_enable,
  // global comparator flags
  input wire logic supply_low_lockout,
  input wire logic over_temp,
  input wire logic cool_down,
  input wire logic converter_one_softstart,
  // per-converter comparator flags, index 0 is converter one
  input wire buck_seq_pkg::conv_flags_t [2:0] conv_flags,
  // switch commands
  output logic [2:0] high_side_on,
  output logic [2:0] low_side_on,
  // open-drain power ok pin
  input wire logic power_ok_output_i,
  output logic power_ok_output_o,
  output logic power_ok_output_oe,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // all state of this module
  typedef struct packed {
    logic [buck_seq_pkg::PIN_W-1:0] sync1;   // first synchroniser stage
    logic [buck_seq_pkg::PIN_W-1:0] sync2;   // second synchroniser stage
    logic [buck_seq_pkg::SW_CNT_W-1:0] sw_cnt; // switching period counter
    buck_seq_pkg::seq_state_t seq;           // sequencer state
    logic [1:0] step;                        // stage within the order
    logic [buck_seq_pkg::CNT_W-1:0] tmr;     // shutdown stage gap timer
    logic [2:0] auto_run;                    // run mask from sequencer
    logic thermal;                           // thermal shutdown latched
    logic [2:0] win_ok;                      // window hysteresis per converter
    logic [2:0][buck_seq_pkg::CNT_W-1:0] ss_cnt; // soft-start timers
    logic [buck_seq_pkg::CNT_W-1:0] pok_cnt; // power ok deglitch
    logic pok;                               // power ok released
    logic psm_en;                            // light-load mode enable
    logic bvalid;                            // write response pending
    logic [1:0] bresp;                       // write response code
    logic rvalid;                            // read data pending
    logic [1:0] rresp;                       // read response code
    logic [31:0] rdata;                      // read data
  } top_state_t;

  top_state_t s_r; // registered state
  top_state_t s_nxt; // next state

  // synchronised pin view
  logic [buck_seq_pkg::PIN_W-1:0] pins_raw; // raw pins, packed
  buck_seq_pkg::conv_flags_t [2:0] flags_s; // synchronised flags
  logic mode_s; // sequence select
  logic [2:0] en_s; // enables, index 0 is converter one
  logic lockout_s; // input undervoltage
  logic hot_s; // over-temperature
  logic cool_s; // cool-down reached
  logic ss1_s; // converter one soft-start done
  logic pin_level_s; // power ok pin level

  // derived control
  logic auto_mode; // automatic sequencing active
  logic fault; // lockout or thermal
  logic [2:0] run; // run command per converter
  logic [2:0] hiccup; // converter in hiccup
  logic [2:0] active; // converter switching
  logic [2:0] ss_done; // soft-start finished
  logic tick_one; // cycle start of converter one
  logic tick_two; // cycle start of converters two and three
  logic [5:0] order_up; // start order, three 2-bit indexes
  logic [5:0] order_dn; // stop order, three 2-bit indexes
  logic [1:0] idx; // converter of the current stage
  logic pok_cond; // power ok conditions met
  logic wr_go; // write address and data taken
  logic rd_go; // read address taken
  buck_seq_pkg::status_t status; // status register image

  // order table: {third, second, first}, converter index 0..2
  function automatic logic [5:0] seq_order(input logic en1, input logic en2,
                                           input logic up);
    logic [5:0] o;
    o = 6'h00;
    case ({en1, en2})
      2'h3: o = up ? {2'h2, 2'h1, 2'h0} : {2'h0, 2'h1, 2'h2};
      2'h1: o = up ? {2'h2, 2'h0, 2'h1} : {2'h1, 2'h0, 2'h2};
      2'h2: o = up ? {2'h0, 2'h2, 2'h1} : {2'h1, 2'h2, 2'h0};
      default: o = 6'h00; // reserved, never used
    endcase
    return o;
  endfunction : seq_order

  // pins into one vector for the synchroniser
  assign pins_raw = {conv_flags, sequence_select, converter_three_enable,
                     converter_two_enable, converter_one_enable,
                     supply_low_lockout, over_temp, cool_down,
                     converter_one_softstart, power_ok_output_i};

  // decode second synchroniser stage only
  assign flags_s = s_r.sync2[38:9];
  assign mode_s = s_r.sync2[8];
  assign en_s = s_r.sync2[7:5];
  assign lockout_s = s_r.sync2[4];
  assign hot_s = s_r.sync2[3];
  assign cool_s = s_r.sync2[2];
  assign ss1_s = s_r.sync2[1];
  assign pin_level_s = s_r.sync2[0];

  // switching clocks, converter one half a period later
  assign tick_two = (s_r.sw_cnt == '0);
  assign tick_one = (s_r.sw_cnt == buck_seq_pkg::SW_CNT_W'(buck_seq_pkg::SW_HALF_CYC));

  // mode and run selection
  assign auto_mode = mode_s && (en_s[0] || en_s[1]);
  assign fault = lockout_s || s_r.thermal;
  assign order_up = seq_order(en_s[0], en_s[1], 1'b1);
  assign order_dn = seq_order(en_s[0], en_s[1], 1'b0);
  assign idx = (s_r.seq == buck_seq_pkg::SEQ_DOWN) ?
               order_dn[2*s_r.step +: 2] : order_up[2*s_r.step +: 2];

  // run per converter
  always_comb begin
    if (fault) begin
      run = 3'h0;
    end else if (auto_mode) begin
      run = s_r.auto_run;
    end else if (mode_s) begin
      run = 3'h0; // reserved combination
    end else begin
      run = en_s;
    end
  end

  assign active = run & ~hiccup;

  // soft-start done: pin for one, timer for two, three
  assign ss_done[0] = active[0] && ss1_s;
  assign ss_done[1] = active[1] && (s_r.ss_cnt[1] >= buck_seq_pkg::CNT_W'(SS_CYC));
  assign ss_done[2] = active[2] && (s_r.ss_cnt[2] >= buck_seq_pkg::CNT_W'(SS_CYC));

  // power stage per converter
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cell
      buck_switch_cell #(
        .HIC_WAIT(HIC_WAIT_CYC),
        .HIC_TIME(HIC_TIME_CYC)
      ) u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run[gi]),
        .cycle_start((gi == 0) ? tick_one : tick_two),
        .psm_en(s_r.psm_en),
        .flags(flags_s[gi]),
        .hs_on(high_side_on[gi]),
        .ls_on(low_side_on[gi]),
        .in_hiccup(hiccup[gi])
      );
    end
  endgenerate

  // power ok conditions
  assign pok_cond = (&s_r.win_ok) && (&ss_done) && !fault
                    && (auto_mode ? (s_r.seq == buck_seq_pkg::SEQ_ON) && en_s[2]
                                  : (&en_s) && !mode_s);

  // bus handshakes
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_r.bvalid;
  assign rd_go = s_axi_arvalid && !s_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_r.rvalid;

  // status image
  always_comb begin
    status = '0;
    status.pin_level = pin_level_s;
    status.seq = s_r.seq;
    status.auto_mode = auto_mode;
    status.lockout = lockout_s;
    status.thermal = s_r.thermal;
    status.pok = s_r.pok;
    status.win_ok = s_r.win_ok;
    status.hiccup = hiccup;
    status.active = active;
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    // two-stage synchroniser
    s_nxt.sync1 = pins_raw;
    s_nxt.sync2 = s_r.sync1;
    // switching period counter
    if (s_r.sw_cnt == buck_seq_pkg::SW_CNT_W'(buck_seq_pkg::SW_PERIOD_CYC - 1)) begin
      s_nxt.sw_cnt = '0;
    end else begin
      s_nxt.sw_cnt = s_r.sw_cnt + 1'b1;
    end
    // thermal latch, set wins over the cool-down clear
    if (hot_s) begin
      s_nxt.thermal = 1'b1;
    end else if (cool_s) begin
      s_nxt.thermal = 1'b0;
    end
    // window hysteresis per converter
    for (int i = 0; i < 3; i++) begin
      if (flags_s[i].out_window) begin
        s_nxt.win_ok[i] = 1'b0;
      end else if (flags_s[i].in_window) begin
        s_nxt.win_ok[i] = 1'b1;
      end
      // soft-start timers restart whenever converter stops
      if (!active[i]) begin
        s_nxt.ss_cnt[i] = '0;
      end else if (s_r.ss_cnt[i] < buck_seq_pkg::CNT_W'(SS_CYC)) begin
        s_nxt.ss_cnt[i] = s_r.ss_cnt[i] + 1'b1;
      end
    end
    // sequencer
    case (s_r.seq)
      buck_seq_pkg::SEQ_IDLE: begin
        s_nxt.auto_run = 3'h0;
        s_nxt.step = 2'h0;
        if (auto_mode && en_s[2] && !fault) begin
          s_nxt.seq = buck_seq_pkg::SEQ_UP;
        end
      end
      buck_seq_pkg::SEQ_UP: begin
        s_nxt.auto_run[idx] = 1'b1;
        if (!en_s[2]) begin
          s_nxt.seq = buck_seq_pkg::SEQ_DOWN;
          s_nxt.step = 2'h0;
          s_nxt.tmr = '0;
        end else if (ss_done[idx]) begin
          // next stage only after previous ramp ends
          if (s_r.step == 2'h2) begin
            s_nxt.seq = buck_seq_pkg::SEQ_ON;
          end else begin
            s_nxt.step = s_r.step + 1'b1;
          end
        end
      end
      buck_seq_pkg::SEQ_ON: begin
        if (!en_s[2]) begin
          s_nxt.seq = buck_seq_pkg::SEQ_DOWN;
          s_nxt.step = 2'h0;
          s_nxt.tmr = '0;
        end
      end
      buck_seq_pkg::SEQ_DOWN: begin
        s_nxt.auto_run[idx] = 1'b0;
        s_nxt.tmr = s_r.tmr + 1'b1;
        if (s_r.tmr >= buck_seq_pkg::CNT_W'(STOP_GAP_CYC - 1)) begin
          s_nxt.tmr = '0;
          if (s_r.step == 2'h2) begin
            s_nxt.seq = buck_seq_pkg::SEQ_IDLE;
          end else begin
            s_nxt.step = s_r.step + 1'b1;
          end
        end
      end
      default: begin
        s_nxt.seq = buck_seq_pkg::SEQ_IDLE;
      end
    endcase
    // fault or leaving auto mode aborts the sequence
    if (fault || !auto_mode) begin
      s_nxt.seq = buck_seq_pkg::SEQ_IDLE;
      s_nxt.auto_run = 3'h0;
      s_nxt.step = 2'h0;
    end
    // power ok deglitch, any loss drops it at once
    if (!pok_cond) begin
      s_nxt.pok_cnt = '0;
      s_nxt.pok = 1'b0;
    end else if (s_r.pok_cnt >= buck_seq_pkg::CNT_W'(POK_DEGLITCH_CYC - 1)) begin
      s_nxt.pok = 1'b1;
    end else begin
      s_nxt.pok_cnt = s_r.pok_cnt + 1'b1;
    end
    // write channel: address and data taken together
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = buck_seq_pkg::RESP_OKAY;
      if (s_axi_awaddr == buck_seq_pkg::REG_CONTROL) begin
        if (s_axi_wstrb[0]) begin
          s_nxt.psm_en = s_axi_wdata[buck_seq_pkg::CTRL_PSM_BIT];
        end
      end else if (s_axi_awaddr != buck_seq_pkg::REG_STATUS) begin
        s_nxt.bresp = buck_seq_pkg::RESP_SLVERR; // unmapped
      end
    end
    // read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = buck_seq_pkg::RESP_OKAY;
      if (s_axi_araddr == buck_seq_pkg::REG_CONTROL) begin
        s_nxt.rdata = {31'h0, s_r.psm_en};
      end else if (s_axi_araddr == buck_seq_pkg::REG_STATUS) begin
        s_nxt.rdata = status;
      end else begin
        s_nxt.rdata = 32'h0; // unmapped
        s_nxt.rresp = buck_seq_pkg::RESP_SLVERR;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.seq <= buck_seq_pkg::SEQ_IDLE;
      s_r.psm_en <= buck_seq_pkg::CTRL_PSM_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // open-drain pin pulls low unless power ok
  assign power_ok_output_o = 1'b0;
  assign power_ok_output_oe = !s_r.pok;

  // bus outputs from flip-flops
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;

endmodule : buck_sequencer

// file: buck_stage_model.sv
`timescale 1ns/1ps

module buck_stage_model (
  // clock and switch commands
  input wire logic aclk,
  input wire logic [2:0] high_side_on,
  input wire logic [2:0] low_side_on,
  // faults forced by the bench
  input wire buck_seq_pkg::conv_flags_t [2:0] inject,
  // comparator flags and pins
  output buck_seq_pkg::conv_flags_t [2:0] conv_flags,
  output logic converter_one_softstart,
  input wire logic power_ok_output_oe,
  output logic power_ok_pin
);
  logic [8:0] on_cnt [3] = '{default: 9'h000}; // cycles of unbroken switching
  logic [4:0] hs_cnt [3] = '{default: 5'h00}; // high-side on-time
  logic [4:0] ls_cnt [3] = '{default: 5'h00}; // low-side on-time
  // pull-up: released pin reads high
  assign power_ok_pin = !power_ok_output_oe;
  // stage one ramp done after long switching
  assign converter_one_softstart = on_cnt[0] > 9'h12C;
  // counters follow the switch commands
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      hs_cnt[i] <= high_side_on[i] ? hs_cnt[i] + 5'h01 : 5'h00;
      ls_cnt[i] <= low_side_on[i] ? ls_cnt[i] + 5'h01 : 5'h00;
      if (!(high_side_on[i] || low_side_on[i])) on_cnt[i] <= 9'h000;
      else if (on_cnt[i] != 9'h1FF) on_cnt[i] <= on_cnt[i] + 9'h001;
    end
  end
  // window follows switching, current ramps
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      conv_flags[i] = inject[i];
      conv_flags[i].in_window = inject[i].in_window | (on_cnt[i] > 9'h0C8);
      conv_flags[i].out_window = inject[i].out_window | (on_cnt[i] < 9'h064);
      conv_flags[i].peak_trip = inject[i].peak_trip | (hs_cnt[i] >= 5'h14);
      conv_flags[i].zero_cur = inject[i].zero_cur | (ls_cnt[i] >= 5'h0F);
    end
  end
endmodule : buck_stage_model

// file: buck_seq_monitor.sv
`timescale 1ns/1ps

module buck_seq_monitor (
  // clock, reset and pins
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sequence_select,
  input wire logic converter_two_enable,
  input wire logic supply_low_lockout,
  input wire logic over_temp,
  input wire buck_seq_pkg::conv_flags_t [2:0] conv_flags,
  // outputs watched
  input wire logic [2:0] high_side_on,
  input wire logic [2:0] low_side_on,
  input wire logic power_ok_output_o,
  input wire logic power_ok_output_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // flags held long enough to pass the synchroniser
  sequence lock_held; supply_low_lockout [*4]; endsequence
  sequence hot_held; over_temp [*5]; endsequence
  lock_off_a: assert property (lock_held |-> {high_side_on, low_side_on} == 6'h00)
    else $error("on in lockout");
  hot_off_a: assert property (hot_held |-> {high_side_on, low_side_on} == 6'h00)
    else $error("on while hot");
  boot_hs_a: assert property (conv_flags[1].boot_low [*4] |-> !high_side_on[1])
    else $error("hs on, boot low");
  over_hs_a: assert property (conv_flags[0].overshoot [*4] |-> !high_side_on[0])
    else $error("hs on, overshoot");
  low_err_a: assert property (conv_flags[2].err_low [*4] |-> !(high_side_on[2] || low_side_on[2]))
    else $error("on, error low");
  sink_off_a: assert property (conv_flags[2].sink_limit [*4] |-> !(high_side_on[2] || low_side_on[2]))
    else $error("on, sink limit");
  pok_out_a: assert property (conv_flags[1].out_window [*5] |-> power_ok_output_oe)
    else $error("pok out of window");
  pok_lock_a: assert property (lock_held |-> power_ok_output_oe)
    else $error("pok in lockout");
  pok_od_a: assert property (power_ok_output_o == 1'b0)
    else $error("pok driven high");
  man_off_a: assert property ((!sequence_select && !converter_two_enable) [*4]
    |-> !(high_side_on[1] || low_side_on[1]))
    else $error("stage two on");
endmodule : buck_seq_monitor

bind buck_sequencer buck_seq_monitor mon_u (.*);

// file: test_triple_buck_sequencer_supervisor.sv
`timescale 1ns/1ps

module test_triple_buck_sequencer_supervisor;
  logic aclk = 1'b0, aresetn = 1'b0, sequence_select = 1'b0;
  logic converter_one_enable = 1'b0, converter_two_enable = 1'b0, converter_three_enable = 1'b0;
  logic supply_low_lockout = 1'b0, over_temp = 1'b0, cool_down = 1'b0;
  logic converter_one_softstart, power_ok_output_i, power_ok_output_o, power_ok_output_oe;
  buck_seq_pkg::conv_flags_t [2:0] conv_flags;
  buck_seq_pkg::conv_flags_t [2:0] inject = '0; // bench-forced faults
  logic [2:0] high_side_on, low_side_on;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, rnd = 32'hD04B;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] seq;
  int mismatches = 0, cmp_count = 0;
  int fl[5] = '{8, 7, 6, 3, 1}; // flag bits: out window, overshoot, boot, err low, sink
  buck_sequencer #(.SS_CYC(300), .HIC_WAIT_CYC(10), .HIC_TIME_CYC(30),
    .POK_DEGLITCH_CYC(8), .STOP_GAP_CYC(200)) dut_u (.*);
  buck_stage_model stage_u (.power_ok_pin(power_ok_output_i), .*);
  // 50 MHz clock
  always #10 aclk = ~aclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic stat;
    bus(1'b0, buck_seq_pkg::REG_STATUS, 32'h0);
  endtask : stat
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one register access, called just after an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    do @(posedge aclk); while (!(wr ? s_axi_awready && s_axi_wready : s_axi_arready));
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    {s_axi_bready, s_axi_rready} <= {wr, !wr};
    do @(posedge aclk); while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    {s_axi_bready, s_axi_rready} <= 2'h0;
    rsp = wr ? s_axi_bresp : s_axi_rresp;
    rd = s_axi_rdata;
  endtask : bus
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected order by {en1, en2, up}, first stage in top pair
  function automatic logic [5:0] exp_order(input logic [2:0] sel);
    logic [5:0] t[8] = '{6'h3F, 6'h3F, 6'h21, 6'h12, 6'h09, 6'h18, 6'h24, 6'h06};
    return t[sel];
  endfunction : exp_order
  // moves run pin, logs stages as active bits change
  task automatic order(input logic en3, output logic [5:0] s);
    logic [2:0] prev;
    stat;
    prev = rd[2:0];
    s = 6'h3F;
    converter_three_enable <= en3;
    repeat (400) begin
      stat;
      for (int i = 0; i < 3; i++) if (rd[i] !== prev[i]) s = {s[3:0], 2'(i)};
      prev = rd[2:0];
    end
  endtask : order
  task automatic do_reset;
    aresetn <= 1'b0;
    converter_three_enable <= 1'b0;
    cyc(4);
    aresetn <= 1'b1;
    bus(1'b1, buck_seq_pkg::REG_CONTROL, 32'h0); // light-load cutoff off
  endtask : do_reset
  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    #1ms;
    mismatches++;
    complete_run;
  end
  // main sequence
  initial begin
    cyc(4);
    aresetn <= 1'b1;
    bus(1'b0, buck_seq_pkg::REG_CONTROL, 32'h0);
    check(rd, 32'h1);
    check(32'(rsp), 32'(buck_seq_pkg::RESP_OKAY));
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    check(32'(rsp), 32'(buck_seq_pkg::RESP_SLVERR));
    repeat (4) begin
      rnd = xs(rnd);
      bus(1'b1, buck_seq_pkg::REG_CONTROL, rnd);
      bus(1'b0, buck_seq_pkg::REG_CONTROL, 32'h0);
      check(rd, {31'h0, rnd[0]});
    end
    bus(1'b1, buck_seq_pkg::REG_CONTROL, 32'h0);
    // manual mode, all stages on
    {converter_one_enable, converter_two_enable, converter_three_enable} <= 3'h7;
    for (int t = 0; t < 3000 && power_ok_output_oe !== 1'b0; t++) cyc(1);
    check(32'(power_ok_output_i), 32'h1);
    foreach (fl[j]) begin
      inject <= {3{10'(1) << fl[j]}};
      cyc(6);
      if (j == 0) check(32'(power_ok_output_oe), 32'h1);
      inject <= '0;
      cyc(400);
    end
    inject[2].overload <= 1'b1;
    cyc(30);
    stat;
    check(32'(rd[5:3]), 32'h4);
    inject <= '0;
    cyc(60);
    stat;
    check(32'(rd[5:3]), 32'h0);
    converter_two_enable <= 1'b0;
    cyc(10);
    stat;
    check(32'(rd[2:0]), 32'h5);
    check(32'(power_ok_output_oe), 32'h1);
    converter_two_enable <= 1'b1;
    supply_low_lockout <= 1'b1;
    cyc(6);
    check(32'({high_side_on, low_side_on}), 32'h0);
    check(32'(power_ok_output_i), 32'h0);
    supply_low_lockout <= 1'b0;
    over_temp <= 1'b1;
    cyc(6);
    stat;
    check(32'({rd[10], high_side_on, low_side_on}), 32'h40);
    over_temp <= 1'b0;
    cool_down <= 1'b1;
    cyc(20);
    stat;
    check(32'({rd[10], rd[2:0]}), 32'h7);
    cool_down <= 1'b0;
    // automatic orders for every enable pair
    for (int k = 3; k >= 0; k--) begin
      do_reset;
      sequence_select <= 1'b1;
      {converter_one_enable, converter_two_enable} <= 2'(k);
      cyc(5);
      order(1'b1, seq);
      check(32'(seq), 32'(exp_order({2'(k), 1'b1})));
      order(1'b0, seq);
      check(32'(seq), 32'(exp_order({2'(k), 1'b0})));
    end
    complete_run;
  end
endmodule : test_triple_buck_sequencer_supervisor
